// file: pclc_top.sv
// Behaviour
// RULE_01 - 17 to 21 edges select address 1-5
// RULE_02 - 1 to 16 edges write data
// RULE_03 - Each register holds four bits
// RULE_04 - Latch only after high for latch timeout
// RULE_05 - Host sends address, pause, data, pause
// RULE_06 - Repeated data bursts reuse latched address
// RULE_07 - Long low enters shutdown, sinks off
// RULE_08 - Shutdown resets every register to one
// RULE_09 - Address one selected after shutdown
// RULE_10 - Address 1 both, 2 main, 3 sub
// RULE_11 - Address 4 range, address 5 low
// RULE_12 - Ranges 1-3 use table currents
// RULE_13 - Range 4 uses low-current register
// RULE_14 - Code 1 full, 16 zero current
// RULE_15 - Code 1 gives 20/30/15 mA
// RULE_16 - Default range is 20 mA
// RULE_17 - Accept edge rates above 1 MHz
// RULE_18 - Pump goes 1.5X then 2X on dropout
// RULE_19 - Range 1 20, 2 30, 3 15 mA
// RULE_20 - Host writes 4 then low setting
// RULE_21 - Host keeps burst highs under 75 us
// RULE_22 - Clear count on latch, drop above 21
// RULE_23 - Timeouts counted on oscillator ticks
`timescale 1ns/1ps
module pclc_top #(
  // Timeouts in oscillator ticks
  parameter int LATCH_TICKS = pclc_pkg::LATCH_OSC_TICKS,
  parameter int OFF_TICKS = pclc_pkg::OFF_OSC_TICKS
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Control pin
  input wire ctrl_pin,
  // Dropout sense from the sinks
  input wire dropout_near,
  // Drive outputs
  output logic enabled,
  output logic low_mode,
  output logic [pclc_pkg::CUR_W-1:0] main_led_sinks,
  output logic [pclc_pkg::CUR_W-1:0] sub_led_sinks,
  output pclc_pkg::pclc_pump_e pump_mode
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Burst count that carries a data value
  function automatic logic pclc_is_data(input logic [4:0] cnt);
    pclc_is_data = (cnt >= pclc_pkg::DATA_MIN) && (cnt <= pclc_pkg::DATA_MAX);
  endfunction : pclc_is_data

  // Burst count that selects an address
  function automatic logic pclc_is_addr(input logic [4:0] cnt);
    pclc_is_addr = (cnt > pclc_pkg::DATA_MAX) &&
                   (cnt <= pclc_pkg::ADDR_MAX_EDGES);
  endfunction : pclc_is_addr

  // Tick count cut to the counter width
  function automatic logic [pclc_pkg::TICK_W-1:0] pclc_ticks(input int n);
    pclc_ticks = pclc_pkg::TICK_W'(n);
  endfunction : pclc_ticks

  // ----------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  logic rise;
  logic fall;

  // Two-stage synchroniser, then history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= ctrl_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // Edges sampled at 250 MHz, well above 1 MHz bursts
  assign rise = pin_sync_r & ~pin_prev_r; // RULE_17
  assign fall = ~pin_sync_r & pin_prev_r;

  // ----------------------------------------
  // Oscillator tick divider
  // ----------------------------------------
  logic [7:0] div_r;
  logic tick;

  // One-cycle 1 MHz enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 8'h00;
    end else if (div_r == 8'(pclc_pkg::OSC_DIV - 1)) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign tick = (div_r == 8'(pclc_pkg::OSC_DIV - 1));

  // ----------------------------------------
  // Timeout counters
  // ----------------------------------------
  logic [pclc_pkg::TICK_W-1:0] hi_cnt_r;
  logic [pclc_pkg::TICK_W-1:0] lo_cnt_r;
  logic latch_hit;
  logic off_hit;

  // High time, restarted on each rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_r <= '0;
    end else if (rise || !pin_sync_r) begin
      hi_cnt_r <= '0; // RULE_23
    end else if (tick && hi_cnt_r != pclc_ticks(LATCH_TICKS)) begin
      hi_cnt_r <= hi_cnt_r + pclc_ticks(1);
    end
  end

  // Low time, restarted on each falling edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_cnt_r <= '0;
    end else if (fall || pin_sync_r) begin
      lo_cnt_r <= '0; // RULE_23
    end else if (tick && lo_cnt_r != pclc_ticks(OFF_TICKS)) begin
      lo_cnt_r <= lo_cnt_r + pclc_ticks(1);
    end
  end

  // Pulses when a count first reaches its timeout
  assign latch_hit = pin_sync_r && tick &&
    hi_cnt_r == pclc_ticks(LATCH_TICKS - 1); // RULE_04
  assign off_hit = !pin_sync_r && tick &&
    lo_cnt_r == pclc_ticks(OFF_TICKS - 1); // RULE_07

  // ----------------------------------------
  // Enable and edge counting
  // ----------------------------------------
  logic enabled_r;
  logic [4:0] edge_cnt_r;
  logic [2:0] addr_r;
  logic is_data;
  logic is_addr;

  // Shutdown after long low, wake on a rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enabled_r <= 1'b0;
    end else if (off_hit) begin
      enabled_r <= 1'b0; // RULE_07
    end else if (rise) begin
      enabled_r <= 1'b1;
    end
  end

  // Burst edge counter, saturating, cleared on latch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_cnt_r <= '0;
    end else if (off_hit || latch_hit) begin
      edge_cnt_r <= '0; // RULE_22
    end else if (rise && edge_cnt_r != pclc_pkg::CNT_SAT) begin
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end

  assign is_data = pclc_is_data(edge_cnt_r); // RULE_02
  assign is_addr = pclc_is_addr(edge_cnt_r); // RULE_01

  // Selected address, back to 1 on shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= pclc_pkg::ADDR_BOTH;
    end else if (off_hit) begin
      addr_r <= pclc_pkg::ADDR_BOTH; // RULE_09
    end else if (latch_hit && is_addr) begin
      addr_r <= 3'(edge_cnt_r - pclc_pkg::ADDR_BASE); // RULE_01
    end
  end

  // ----------------------------------------
  // Register file (stored as value minus one)
  // ----------------------------------------
  localparam logic [3:0] REG_CLEAR = pclc_pkg::REG_RESET - 4'h1;
  logic [3:0] main_lvl_r;
  logic [3:0] sub_lvl_r;
  logic [3:0] range_r;
  logic [3:0] low_set_r;
  logic [3:0] wdata;
  logic wr_en;
  logic wr_main;
  logic wr_sub;
  logic wr_range;
  logic wr_low;
  pclc_pkg::pclc_regs_s regs;

  assign wdata = 4'(edge_cnt_r - 5'h01); // RULE_03
  assign wr_en = latch_hit && is_data; // RULE_06

  // Route a data write to the fields of the held address
  always_comb begin
    wr_main = 1'b0;
    wr_sub = 1'b0;
    wr_range = 1'b0;
    wr_low = 1'b0;
    if (addr_r == pclc_pkg::ADDR_BOTH) begin
      wr_main = wr_en; // RULE_10
      wr_sub = wr_en;
    end else if (addr_r == pclc_pkg::ADDR_MAIN) begin
      wr_main = wr_en; // RULE_10
    end else if (addr_r == pclc_pkg::ADDR_SUB) begin
      wr_sub = wr_en; // RULE_10
    end else if (addr_r == pclc_pkg::ADDR_RANGE) begin
      wr_range = wr_en; // RULE_11
    end else if (addr_r == pclc_pkg::ADDR_LOW) begin
      wr_low = wr_en; // RULE_11
    end
  end

  // Main group code, back to one on shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_lvl_r <= REG_CLEAR;
    end else if (off_hit) begin
      main_lvl_r <= REG_CLEAR; // RULE_08
    end else if (wr_main) begin
      main_lvl_r <= wdata;
    end
  end

  // Sub group code, back to one on shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_lvl_r <= REG_CLEAR;
    end else if (off_hit) begin
      sub_lvl_r <= REG_CLEAR; // RULE_08
    end else if (wr_sub) begin
      sub_lvl_r <= wdata;
    end
  end

  // Full-scale range, 20 mA scale while cleared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      range_r <= REG_CLEAR; // RULE_16
    end else if (off_hit) begin
      range_r <= REG_CLEAR; // RULE_08
    end else if (wr_range) begin
      range_r <= wdata;
    end
  end

  // Low-current setting, back to one on shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_set_r <= REG_CLEAR;
    end else if (off_hit) begin
      low_set_r <= REG_CLEAR; // RULE_08
    end else if (wr_low) begin
      low_set_r <= wdata;
    end
  end

  // Fields gathered for the current map
  assign regs = {main_lvl_r, sub_lvl_r, range_r, low_set_r};

  // ----------------------------------------
  // Current resolution
  // ----------------------------------------
  pclc_pkg::pclc_drive_s drive;

  // Range 0 stored means 20 mA scale after reset
  pclc_level_map u_map ( // RULE_16
    .regs(regs),
    .drive(drive)
  );

  // Enable flag out
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enabled <= 1'b0;
    end else begin
      enabled <= enabled_r; // RULE_07
    end
  end

  // Low-current mode flag out, off in shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_mode <= 1'b0;
    end else begin
      low_mode <= enabled_r & drive.low_mode; // RULE_13
    end
  end

  // Main group current out, zero in shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_led_sinks <= '0;
    end else begin
      main_led_sinks <= enabled_r ? drive.main_cur : '0; // RULE_15
    end
  end

  // Sub group current out, zero in shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_led_sinks <= '0;
    end else begin
      sub_led_sinks <= enabled_r ? drive.sub_cur : '0; // RULE_07
    end
  end

  // ----------------------------------------
  // Pump mode controller
  // ----------------------------------------
  logic drop_meta_r;
  logic drop_sync_r;

  // Dropout sense is analogue-side, synchronise it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drop_meta_r <= 1'b0;
      drop_sync_r <= 1'b0;
    end else begin
      drop_meta_r <= dropout_near;
      drop_sync_r <= drop_meta_r;
    end
  end

  // Step 1X to 1.5X to 2X, evaluated each oscillator tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pump_mode <= pclc_pkg::PUMP_1X;
    end else if (!enabled_r) begin
      pump_mode <= pclc_pkg::PUMP_1X; // RULE_07
    end else if (tick && drop_sync_r) begin
      case (pump_mode)
        pclc_pkg::PUMP_1X: pump_mode <= pclc_pkg::PUMP_1P5X; // RULE_18
        pclc_pkg::PUMP_1P5X: pump_mode <= pclc_pkg::PUMP_2X; // RULE_18
        default: pump_mode <= pclc_pkg::PUMP_2X;
      endcase
    end
  end

endmodule : pclc_top

// file: pclc_pkg.sv
package pclc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int OSC_KHZ = 1000;
  localparam int OSC_DIV = CLK_MHZ * 1000 / OSC_KHZ;
  localparam int LATCH_TIMEOUT_US = 500;
  localparam int OFF_TIMEOUT_US = 500;
  localparam int LATCH_OSC_TICKS = LATCH_TIMEOUT_US * OSC_KHZ / 1000;
  localparam int OFF_OSC_TICKS = OFF_TIMEOUT_US * OSC_KHZ / 1000;
  localparam int TICK_W = 10;

  // ----------------------------------------
  // Burst decode
  // ----------------------------------------
  localparam logic [4:0] DATA_MIN = 5'h01;
  localparam logic [4:0] DATA_MAX = 5'h10;
  localparam logic [4:0] ADDR_BASE = 5'h10;
  localparam logic [4:0] ADDR_MAX_EDGES = 5'h15;
  localparam logic [4:0] CNT_SAT = 5'h1f;

  // ----------------------------------------
  // Register addresses and reset value
  // ----------------------------------------
  localparam logic [2:0] ADDR_BOTH = 3'h1;
  localparam logic [2:0] ADDR_MAIN = 3'h2;
  localparam logic [2:0] ADDR_SUB = 3'h3;
  localparam logic [2:0] ADDR_RANGE = 3'h4;
  localparam logic [2:0] ADDR_LOW = 3'h5;
  localparam logic [3:0] REG_RESET = 4'h1;

  // ----------------------------------------
  // Range codes (stored value minus one)
  // ----------------------------------------
  localparam logic [3:0] RANGE_20MA = 4'h0;
  localparam logic [3:0] RANGE_30MA = 4'h1;
  localparam logic [3:0] RANGE_15MA = 4'h2;
  localparam logic [3:0] RANGE_LOW = 4'h3;

  // Sink current in units of 0.1 mA (low mode uses units of 0.05 mA)
  localparam int CUR_W = 9;

  typedef enum logic [1:0] {
    PUMP_1X = 2'b00,
    PUMP_1P5X = 2'b01,
    PUMP_2X = 2'b11
  } pclc_pump_e;

  typedef struct packed {
    logic [3:0] main_level;
    logic [3:0] sub_level;
    logic [3:0] range;
    logic [3:0] low_setting;
  } pclc_regs_s;

  typedef struct packed {
    logic low_mode;
    logic [CUR_W-1:0] main_cur;
    logic [CUR_W-1:0] sub_cur;
  } pclc_drive_s;

endpackage : pclc_pkg

// file: pclc_level_map.sv
`timescale 1ns/1ps
module pclc_level_map (
  // Programmed registers
  input wire pclc_pkg::pclc_regs_s regs,
  // Resolved drive
  output pclc_pkg::pclc_drive_s drive
);

  // Level table, 0.1 mA units
  function automatic logic [8:0] pclc_level(input logic [3:0] code,
                                            input logic [3:0] rng);
    logic [8:0] t20 [16];
    logic [8:0] t30 [16];
    logic [8:0] t15 [16];
    t20 = '{9'd200, 9'd178, 9'd159, 9'd143, 9'd127, 9'd111, 9'd102,
            9'd89, 9'd79, 9'd70, 9'd63, 9'd57, 9'd51, 9'd44, 9'd41, 9'd0};
    t30 = '{9'd300, 9'd267, 9'd238, 9'd214, 9'd190, 9'd167, 9'd152,
            9'd133, 9'd119, 9'd105, 9'd95, 9'd86, 9'd76, 9'd67, 9'd62, 9'd0};
    t15 = '{9'd150, 9'd133, 9'd119, 9'd107, 9'd95, 9'd83, 9'd76,
            9'd67, 9'd60, 9'd52, 9'd48, 9'd43, 9'd38, 9'd33, 9'd31, 9'd0};
    if (rng == pclc_pkg::RANGE_30MA) begin // RULE_19
      pclc_level = t30[code];
    end else if (rng == pclc_pkg::RANGE_15MA) begin
      pclc_level = t15[code];
    end else begin
      pclc_level = t20[code];
    end
  endfunction : pclc_level

  // Low-current table, 0.05 mA units, by level index
  function automatic logic [8:0] pclc_low(input logic [1:0] sel);
    case (sel)
      2'h0: pclc_low = 9'h001;
      2'h1: pclc_low = 9'h00a;
      2'h2: pclc_low = 9'h014;
      default: pclc_low = 9'h028;
    endcase
  endfunction : pclc_low

  // Resolve the sink currents from the codes
  always_comb begin
    drive.low_mode = (regs.range == pclc_pkg::RANGE_LOW); // RULE_13
    if (drive.low_mode) begin
      // Bit 3 turns the main group on, bit 2 the sub group
      drive.main_cur = regs.low_setting[3] ?
                       pclc_low(regs.low_setting[1:0]) : '0;
      drive.sub_cur = regs.low_setting[2] ?
                      pclc_low(regs.low_setting[1:0]) : '0;
    end else begin
      drive.main_cur = pclc_level(regs.main_level, regs.range); // RULE_12
      drive.sub_cur = pclc_level(regs.sub_level, regs.range); // RULE_14
    end
  end

endmodule : pclc_level_map

// file: pclc_properties.sv
`timescale 1ns/1ps
module pclc_properties #(
  // Off timeout in oscillator ticks, as in the block
  parameter int OFF_TICKS = pclc_pkg::OFF_OSC_TICKS
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Pins in
  input wire ctrl_pin,
  input wire dropout_near,
  // Drive out
  input wire enabled,
  input wire low_mode,
  input wire [pclc_pkg::CUR_W-1:0] main_led_sinks,
  input wire [pclc_pkg::CUR_W-1:0] sub_led_sinks,
  input wire pclc_pkg::pclc_pump_e pump_mode
);
  localparam int OFF_CYC = OFF_TICKS * pclc_pkg::OSC_DIV;
  int low_cnt_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Cycles the pin has stayed low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_r <= 0;
    end else if (ctrl_pin) begin
      low_cnt_r <= 0;
    end else if (low_cnt_r < OFF_CYC + 1000) begin
      low_cnt_r <= low_cnt_r + 1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  shdn_sinks_a: assert property (!enabled |->
    main_led_sinks == '0 && sub_led_sinks == '0)
    else $error("Sinks driven in shutdown");
  shdn_pump_a: assert property (!enabled |->
    pump_mode == pclc_pkg::PUMP_1X && !low_mode)
    else $error("Pump or low mode on in shutdown");
  off_time_a: assert property (low_cnt_r >= OFF_CYC + 600 |->
    !enabled) else $error("No shutdown after long low");
  pump_step_a: assert property (pump_mode == pclc_pkg::PUMP_2X &&
    $past(pump_mode) != pclc_pkg::PUMP_2X |->
    $past(pump_mode) == pclc_pkg::PUMP_1P5X)
    else $error("Pump skipped the middle mode");
  latch_high_a: assert property (enabled && $past(enabled) &&
    ($changed(main_led_sinks) || $changed(sub_led_sinks)) |->
    $past(ctrl_pin, 100)) else $error("Drive changed without a latch");
  en_cause_a: assert property ($rose(enabled) |->
    $past(ctrl_pin, 2)) else $error("Enabled without a pin rise");
  scale_cap_a: assert property (enabled && !low_mode |->
    main_led_sinks <= 9'h12c && sub_led_sinks <= 9'h12c)
    else $error("Sink above full scale");
  low_cap_a: assert property (low_mode |->
    main_led_sinks <= 9'h028 && sub_led_sinks <= 9'h028)
    else $error("Low mode current too high");
endmodule : pclc_properties

bind pclc_top pclc_properties #(.OFF_TICKS(OFF_TICKS)) u_props (.clk(clk),
  .resetn(resetn), .ctrl_pin(ctrl_pin), .dropout_near(dropout_near),
  .enabled(enabled),
  .low_mode(low_mode), .main_led_sinks(main_led_sinks),
  .sub_led_sinks(sub_led_sinks), .pump_mode(pump_mode));

// file: pclc_host.sv
`timescale 1ns/1ps
module pclc_host #(
  // Latch and off timeouts of the block, in oscillator ticks
  parameter int TICKS = pclc_pkg::LATCH_OSC_TICKS
) (
  // Clock
  input wire clk,
  // Control pin
  output logic ctrl_pin
);
  // Pause that outlasts a timeout and its tick phase
  localparam int WAIT_CYC = (TICKS + 1) * pclc_pkg::OSC_DIV;

  initial ctrl_pin = 1'b0;

  // Edge burst, then high past the latch timeout
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ctrl_pin <= 1'b0;
      repeat (80) @(posedge clk);
      ctrl_pin <= 1'b1;
      repeat (79) @(posedge clk);
    end
    repeat (WAIT_CYC) @(posedge clk);
  endtask : send

  // Low past the off timeout
  task automatic off();
    @(posedge clk);
    ctrl_pin <= 1'b0;
    repeat (WAIT_CYC + 700) @(posedge clk); // Reaches the long-low window
  endtask : off
endmodule : pclc_host

// file: tb_pulse_count_led_current_control.sv
`timescale 1ns/1ps
module tb_pulse_count_led_current_control;
  logic clk;
  logic resetn;
  logic dropout_near;
  logic ctrl_pin;
  logic enabled;
  logic low_mode;
  logic [pclc_pkg::CUR_W-1:0] main_led_sinks;
  logic [pclc_pkg::CUR_W-1:0] sub_led_sinks;
  pclc_pkg::pclc_pump_e pump_mode;
  int mismatches;
  int n_checks;
  // Short timeouts keep the run brief
  localparam int TB_TICKS = 8;

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  pclc_host #(.TICKS(TB_TICKS)) u_host (.clk(clk), .ctrl_pin(ctrl_pin));

  pclc_top #(.LATCH_TICKS(TB_TICKS), .OFF_TICKS(TB_TICKS)) DUT (.clk(clk),
    .resetn(resetn), .ctrl_pin(ctrl_pin),
    .dropout_near(dropout_near), .enabled(enabled), .low_mode(low_mode),
    .main_led_sinks(main_led_sinks), .sub_led_sinks(sub_led_sinks),
    .pump_mode(pump_mode));

  // Verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Compare all outputs
  task automatic chk(input logic e, input logic l, input logic [8:0] m,
                     input logic [8:0] s, input pclc_pkg::pclc_pump_e p);
    n_checks++;
    if (enabled !== e || low_mode !== l || main_led_sinks !== m ||
        sub_led_sinks !== s || pump_mode !== p) begin
      mismatches++;
      $display("Error at %0t: got %b %b %0d %0d %b", $time, enabled,
               low_mode, main_led_sinks, sub_led_sinks, pump_mode);
    end
  endtask : chk

  // Optional address burst, then a data burst
  task automatic put(input int a, input int d);
    if (a > 0) begin
      u_host.send(a);
    end
    u_host.send(d);
  endtask : put

  // Data only after power up
  task automatic t_default();
    put(0, 8);
    chk(1'b1, 1'b0, 9'h059, 9'h059, pclc_pkg::PUMP_1X);
    $display("test default done");
  endtask : t_default

  // Range, group writes, refused count
  task automatic t_range();
    put(20, 2);
    chk(1'b1, 1'b0, 9'h085, 9'h085, pclc_pkg::PUMP_1X);
    put(19, 15);
    chk(1'b1, 1'b0, 9'h085, 9'h03e, pclc_pkg::PUMP_1X);
    put(0, 25);
    chk(1'b1, 1'b0, 9'h085, 9'h03e, pclc_pkg::PUMP_1X);
    put(0, 16);
    chk(1'b1, 1'b0, 9'h085, 9'h000, pclc_pkg::PUMP_1X);
    put(20, 3);
    chk(1'b1, 1'b0, 9'h043, 9'h000, pclc_pkg::PUMP_1X);
    put(18, 1);
    chk(1'b1, 1'b0, 9'h096, 9'h000, pclc_pkg::PUMP_1X);
    $display("test range done");
  endtask : t_range

  // Low-current mode
  task automatic t_low();
    put(20, 4);
    put(21, 16);
    chk(1'b1, 1'b1, 9'h028, 9'h028, pclc_pkg::PUMP_1X);
    $display("test low done");
  endtask : t_low

  // Pump steps on dropout
  task automatic t_pump();
    dropout_near <= 1'b1;
    repeat (1000) @(posedge clk);
    chk(1'b1, 1'b1, 9'h028, 9'h028, pclc_pkg::PUMP_2X);
    dropout_near <= 1'b0;
    $display("test pump done");
  endtask : t_pump

  // Shutdown and register reset
  task automatic t_off();
    u_host.off();
    chk(1'b0, 1'b0, 9'h000, 9'h000, pclc_pkg::PUMP_1X);
    put(0, 1);
    chk(1'b1, 1'b0, 9'h0c8, 9'h0c8, pclc_pkg::PUMP_1X);
    $display("test off done");
  endtask : t_off

  // Main sequence
  initial begin
    resetn = 1'b0;
    dropout_near = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_default();
    t_range();
    t_low();
    t_pump();
    t_off();
    test_done();
  end

  // Watchdog
  initial begin
    #360_000;
    mismatches++;
    test_done();
  end
endmodule : tb_pulse_count_led_current_control
